// File: shared/sbt_pkg.sv
// Constants, state encodings and the state record of the memory boundary-scan port.
// Assumes one system clock that oversamples the test clock pin by a wide margin.
package sbt_pkg;

   // Scan register widths
   localparam int unsigned IR_W    = 3;          // Instruction register width
   localparam int unsigned ID_W    = 32;         // Identification register width
   localparam int unsigned BSR_LEN = 107;        // Boundary-scan chain length
   localparam int unsigned OE_CELL = 47;         // Output-bus enable cell index

   // Capture pattern loaded into the instruction shifter
   localparam logic [2:0] IR_CAPTURE = 3'h1;     // Two low bits read binary 01

   // Reset value of the output-bus enable latch
   localparam logic OE_CELL_RST = 1'h1;          // Outputs enabled

   // Pull-up level of unconnected pins
   localparam logic PIN_PULLUP = 1'h1;           // Open pin reads high

   // Resting level of the test clock pin; a spurious fall after reset is harmless
   localparam logic TCK_IDLE = 1'h1;             // Test clock rests high

   // Register map (byte addresses on the bus)
   localparam logic [7:0] REG_CTRL   = 8'h00;    // Control, write one to reset port
   localparam logic [7:0] REG_STATUS = 8'h04;    // Controller state and instruction
   localparam logic [7:0] REG_IDCODE = 8'h08;    // Identification word
   localparam int unsigned CTRL_SOFT_RST = 0;    // Control bit: reset the test port
   localparam int unsigned ST_TAP_LSB    = 0;    // Status: controller state [3:0]
   localparam int unsigned ST_IR_LSB     = 4;    // Status: current instruction [6:4]
   localparam int unsigned ST_TDO_EN     = 8;    // Status: serial output driven
   localparam int unsigned ST_HIZ        = 9;    // Status: output bus floated
   localparam int unsigned ST_OE_CELL    = 10;   // Status: enable cell latch

   // Sixteen controller states
   typedef enum logic [3:0] {
      TAP_RESET  = 4'h0, TAP_IDLE   = 4'h1,
      TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3, TAP_SH_DR  = 4'h4, TAP_EX1_DR = 4'h5,
      TAP_PA_DR  = 4'h6, TAP_EX2_DR = 4'h7, TAP_UPD_DR = 4'h8,
      TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'hA, TAP_SH_IR  = 4'hB, TAP_EX1_IR = 4'hC,
      TAP_PA_IR  = 4'hD, TAP_EX2_IR = 4'hE, TAP_UPD_IR = 4'hF
   } sbt_tap_t;

   // Instruction codes
   typedef enum logic [2:0] {
      INS_EXTEST  = 3'h0, INS_IDCODE = 3'h1, INS_SAMPZ = 3'h2, INS_RSV3 = 3'h3,
      INS_SAMPLE  = 3'h4, INS_RSV5   = 3'h5, INS_RSV6  = 3'h6, INS_BYPASS = 3'h7
   } sbt_ins_t;

   // Classic bus request as seen by the slave
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [7:0]  adr;
      logic [31:0] dat;
   } sbt_wb_req_t;

   // Complete state of the port
   typedef struct packed {
      logic [1:0]         tck_sy;    // Test clock synchroniser
      logic [1:0]         tms_sy;    // Mode select synchroniser
      logic [1:0]         tdi_sy;    // Serial input synchroniser
      logic               tck_prev;  // Previous synchronised clock level
      logic [BSR_LEN-1:0] ring_s1;   // Pin ring, first stage
      logic [BSR_LEN-1:0] ring_s2;   // Pin ring, second stage
      sbt_tap_t           tap;       // Controller state
      logic [IR_W-1:0]    ir_sh;     // Instruction shifter
      sbt_ins_t           ir;        // Current instruction
      logic               byp;       // Bypass bit
      logic [ID_W-1:0]    id_sh;     // Identification shifter
      logic [BSR_LEN-1:0] bsr_sh;    // Boundary shift stage
      logic [BSR_LEN-1:0] bsr_upd;   // Boundary preload latches
      logic               tdo;       // Serial output level
      logic               tdo_oe_n;  // Serial output enable, low drives
      logic               ack;       // Bus acknowledge
      logic [31:0]        rdat;      // Bus read data
      logic               soft_rst;  // Software reset pulse
   } sbt_state_t;

endpackage : sbt_pkg

// File: src/sbt_tap.sv
// Boundary-scan test port of a pipelined memory, oversampling the test clock pin.
// Assumes test pins and memory pin ring are asynchronous; bus is on i_clock.
//
// Behaviour
// (RQ1) Open test input pins read high; idle clock disables
// (RQ2) Sample on clock rise, output on fall
// (RQ3) Shift in at MSB, out at LSB
// (RQ4) Power-up reset; output floats outside shift states
// (RQ5) Five high mode-select edges reset controller
// (RQ6) Three-bit instruction, identify after any reset
// (RQ7) Instruction capture loads binary 01 low bits
// (RQ8) Exactly one data register chosen by instruction
// (RQ9) Single bypass bit, cleared on execution
// (RQ10) Data capture loads all pins, then shifts
// (RQ11) Identify instruction captures hardwired 32-bit code
// (RQ12) Tester never loads the three reserved codes
// (RQ13) Instruction shifted, effective at instruction update
// (RQ14) Identify code shifts out in data shift
// (RQ15) Floating sample selects chain, floats output bus
// (RQ16) Sample snapshot of pins leaves memory alone
// (RQ17) Shift out while shifting in; update latches
// (RQ18) External test drives preload, selects chain
// (RQ19) Cell 47 enables output bus under external test
// (RQ20) Enable cell latch high at power-up, reset
// (RQ21) Tester keeps pins stable across capture
// (RQ22) Instruction codes decode per table
// (RQ23) Identification word layout: revision, device, vendor, one
// (RQ24) Boundary chain is 107 cells
// (RQ25) Standard sixteen-state controller on clock rises
`timescale 1ns/10ps

module sbt_tap
   import sbt_pkg::*;
#(
   parameter logic [2:0]  ID_REV    = 3'h2,      // Revision, arbitrary value
   parameter logic [16:0] ID_DEVICE = 17'h0ABCD, // Device field, arbitrary value
   parameter logic [10:0] ID_VENDOR = 11'h155    // Vendor field, arbitrary value
) (
   input  wire logic               i_clock,        // System clock, 125 MHz
   input  wire logic               i_sys_rst,      // Synchronous reset, power-up
   input  wire logic               i_clk_en,       // Freezes all state when low
   input  wire logic               i_tck,          // Test clock pin
   input  wire logic               i_tms,          // Mode select pin
   input  wire logic               i_tdi,          // Serial data in pin
   output logic                    o_tdo,          // Serial data out
   output logic                    o_tdo_oe_n,     // Serial out enable, low drives
   input  wire logic [BSR_LEN-1:0] i_ring,         // Memory pin ring levels
   output logic      [BSR_LEN-1:0] o_preload,      // Preload latches
   output logic                    o_ring_drive,   // Drive preload onto pins
   output logic                    o_qbus_hiz,     // Float memory output bus
   input  wire logic               i_wb_cyc,       // Bus cycle
   input  wire logic               i_wb_stb,       // Bus strobe
   input  wire logic               i_wb_we,        // Bus write
   input  wire logic [3:0]         i_wb_sel,       // Bus byte selects
   input  wire logic [7:0]         i_wb_adr,       // Bus byte address
   input  wire logic [31:0]        i_wb_dat,       // Bus write data
   output logic                    o_wb_ack,       // Bus acknowledge
   output logic      [31:0]        o_wb_dat        // Bus read data
);

   // Hardwired identification word, bit 0 always one
   localparam logic [ID_W-1:0] ID_WORD = {ID_REV, ID_DEVICE, ID_VENDOR, 1'h1}; // RQ23

   sbt_state_t  st_ff;      // Registered state
   sbt_state_t  nxt_st;     // Next state
   sbt_wb_req_t wb;         // Gathered bus request
   logic        tck_rise;   // Synchronised test clock rose
   logic        tck_fall;   // Synchronised test clock fell
   logic        tms;        // Synchronised mode select
   logic        tdi;        // Synchronised serial input
   logic        sel_bsr;    // Boundary chain selected
   logic        sel_id;     // Identification register selected
   logic        dr_lsb;     // Low bit of selected data register
   logic        bus_req;    // New bus request this cycle
   logic [31:0] status;     // Status word

   // Bundle bus inputs
   always_comb begin
      wb.cyc = i_wb_cyc;
      wb.stb = i_wb_stb;
      wb.we  = i_wb_we;
      wb.sel = i_wb_sel;
      wb.adr = i_wb_adr;
      wb.dat = i_wb_dat;
   end

   // Edge detection on second synchroniser stage only
   assign tck_rise = st_ff.tck_sy[1] & ~st_ff.tck_prev;   // RQ2
   assign tck_fall = ~st_ff.tck_sy[1] & st_ff.tck_prev;   // RQ2
   assign tms      = st_ff.tms_sy[1];
   assign tdi      = st_ff.tdi_sy[1];

   // Data register choice; reserved codes fall back to bypass
   always_comb begin
      sel_bsr = 1'b0;
      sel_id  = 1'b0;
      case (st_ff.ir)                                         // RQ22
         INS_EXTEST, INS_SAMPZ, INS_SAMPLE: sel_bsr = 1'b1; // RQ8
         INS_IDCODE:                        sel_id  = 1'b1; // RQ8
         default:                           sel_bsr = 1'b0;
      endcase
   end

   // Low bit of whichever data register sits on the path
   always_comb begin
      if (sel_bsr) begin
         dr_lsb = st_ff.bsr_sh[0];                          // RQ3
      end else if (sel_id) begin
         dr_lsb = st_ff.id_sh[0];                           // RQ3
      end else begin
         dr_lsb = st_ff.byp;
      end
   end

   // Status word for software
   always_comb begin
      status = 32'h0000_0000;
      status[ST_TAP_LSB +: 4]  = st_ff.tap;
      status[ST_IR_LSB +: IR_W] = st_ff.ir;
      status[ST_TDO_EN]        = ~st_ff.tdo_oe_n;
      status[ST_HIZ]           = o_qbus_hiz;
      status[ST_OE_CELL]       = st_ff.bsr_upd[OE_CELL];
   end

   assign bus_req = wb.cyc & wb.stb & ~st_ff.ack;

   // Next state of the whole port
   always_comb begin
      nxt_st = st_ff;

      // Synchronisers; pins sampled only through two stages
      nxt_st.tck_sy   = {st_ff.tck_sy[0], i_tck};
      nxt_st.tms_sy   = {st_ff.tms_sy[0], i_tms};
      nxt_st.tdi_sy   = {st_ff.tdi_sy[0], i_tdi};
      nxt_st.tck_prev = st_ff.tck_sy[1];
      nxt_st.ring_s1  = i_ring;
      nxt_st.ring_s2  = st_ff.ring_s1;

      // Controller advance and register actions on test clock rise
      if (tck_rise) begin                                      // RQ25
         case (st_ff.tap)
            TAP_RESET:  nxt_st.tap = tms ? TAP_RESET  : TAP_IDLE;
            TAP_IDLE:   nxt_st.tap = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: nxt_st.tap = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: nxt_st.tap = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR:  nxt_st.tap = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: nxt_st.tap = tms ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR:  nxt_st.tap = tms ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: nxt_st.tap = tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: nxt_st.tap = tms ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: nxt_st.tap = tms ? TAP_RESET  : TAP_CAP_IR; // RQ5
            TAP_CAP_IR: nxt_st.tap = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR:  nxt_st.tap = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: nxt_st.tap = tms ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR:  nxt_st.tap = tms ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: nxt_st.tap = tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: nxt_st.tap = tms ? TAP_SEL_DR : TAP_IDLE;
            default:    nxt_st.tap = TAP_RESET;
         endcase

         case (st_ff.tap)
            // Instruction path
            TAP_CAP_IR: nxt_st.ir_sh = IR_CAPTURE;                    // RQ7
            TAP_SH_IR:  nxt_st.ir_sh = {tdi, st_ff.ir_sh[IR_W-1:1]};  // RQ3
            TAP_UPD_IR: begin
               nxt_st.ir = sbt_ins_t'(st_ff.ir_sh);                   // RQ13
               if (sbt_ins_t'(st_ff.ir_sh) == INS_BYPASS) begin
                  nxt_st.byp = 1'b0;                                  // RQ9
               end
            end
            // Data capture by current instruction
            TAP_CAP_DR: begin
               if (sel_bsr) begin
                  nxt_st.bsr_sh = st_ff.ring_s2;                      // RQ10 RQ16
               end else if (sel_id) begin
                  nxt_st.id_sh = ID_WORD;                             // RQ11
               end else begin
                  nxt_st.byp = 1'b0;                                  // RQ9
               end
            end
            // Data shift through the one selected register
            TAP_SH_DR: begin
               if (sel_bsr) begin
                  nxt_st.bsr_sh = {tdi, st_ff.bsr_sh[BSR_LEN-1:1]};   // RQ17 RQ24
               end else if (sel_id) begin
                  nxt_st.id_sh = {tdi, st_ff.id_sh[ID_W-1:1]};        // RQ14
               end else begin
                  nxt_st.byp = tdi;                                   // RQ9
               end
            end
            // Preload latches follow the shift stage under sample and external test
            TAP_UPD_DR: begin
               if (st_ff.ir == INS_SAMPLE || st_ff.ir == INS_EXTEST) begin
                  nxt_st.bsr_upd = st_ff.bsr_sh;                      // RQ17
               end
            end
            default: nxt_st.ir_sh = st_ff.ir_sh;
         endcase
      end

      // Serial output changes on the falling edge only
      if (tck_fall) begin                                      // RQ2
         if (st_ff.tap == TAP_SH_IR) begin
            nxt_st.tdo      = st_ff.ir_sh[0];                 // RQ3
            nxt_st.tdo_oe_n = 1'b0;                           // RQ4
         end else if (st_ff.tap == TAP_SH_DR) begin
            nxt_st.tdo      = dr_lsb;                         // RQ8
            nxt_st.tdo_oe_n = 1'b0;                           // RQ4
         end else begin
            nxt_st.tdo_oe_n = 1'b1;                           // RQ4
         end
      end

      // Logic-reset state holds identify and the enable latch
      if (st_ff.tap == TAP_RESET) begin
         nxt_st.ir               = INS_IDCODE;                // RQ6
         nxt_st.bsr_upd[OE_CELL] = OE_CELL_RST;               // RQ20
         nxt_st.tdo_oe_n         = 1'b1;                      // RQ4
      end

      // Software reset of the test port
      if (st_ff.soft_rst) begin
         nxt_st.tap      = TAP_RESET;                          // RQ5
         nxt_st.ir       = INS_IDCODE;                         // RQ6
         nxt_st.tdo_oe_n = 1'b1;                               // RQ4
      end

      // Bus slave: acknowledge one cycle after a request, then drop
      nxt_st.soft_rst = 1'b0;
      nxt_st.ack      = bus_req;
      if (bus_req) begin
         nxt_st.rdat = 32'h0000_0000;
         if (!wb.we) begin
            case (wb.adr)
               REG_STATUS: nxt_st.rdat = status;
               REG_IDCODE: nxt_st.rdat = ID_WORD;
               default:    nxt_st.rdat = 32'h0000_0000;
            endcase
         end else if (wb.adr == REG_CTRL && wb.sel[0]) begin
            nxt_st.soft_rst = wb.dat[CTRL_SOFT_RST];
         end
      end
   end

   // Register the state; reset acts on the clock
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         st_ff                  <= '0;
         st_ff.tck_sy           <= {2{TCK_IDLE}};             // No false rise after reset
         st_ff.tck_prev         <= TCK_IDLE;                  // Edge detector at rest level
         st_ff.tms_sy           <= {2{PIN_PULLUP}};           // RQ1
         st_ff.tdi_sy           <= {2{PIN_PULLUP}};           // RQ1
         st_ff.tap              <= TAP_RESET;                 // RQ4
         st_ff.ir               <= INS_IDCODE;                // RQ6
         st_ff.ir_sh            <= IR_CAPTURE;
         st_ff.bsr_upd[OE_CELL] <= OE_CELL_RST;               // RQ20
         st_ff.tdo_oe_n         <= 1'b1;                      // RQ4
      end else if (i_clk_en) begin
         st_ff <= nxt_st;
      end
   end

   // Outputs
   assign o_tdo        = st_ff.tdo;
   assign o_tdo_oe_n   = st_ff.tdo_oe_n;
   assign o_preload    = st_ff.bsr_upd;
   assign o_ring_drive = (st_ff.ir == INS_EXTEST);                              // RQ18
   assign o_qbus_hiz   = (st_ff.ir == INS_SAMPZ) ||                             // RQ15
                         (st_ff.ir == INS_EXTEST && !st_ff.bsr_upd[OE_CELL]);   // RQ19
   assign o_wb_ack     = st_ff.ack;
   assign o_wb_dat     = st_ff.rdat;

endmodule : sbt_tap

// File: tb/sbt_tap_assertions.sv
// Concurrent checks on the pins and bus of the memory boundary-scan port.
// Assumes binding to sbt_tap; everything sits on the one system clock.
`timescale 1ns/10ps
module sbt_tap_assertions
   import sbt_pkg::*;
(
   input wire logic               i_clock,
   input wire logic               i_sys_rst,
   input wire logic               i_clk_en,
   input wire logic               i_tck,
   input wire logic               i_tms,
   input wire logic               o_tdo,
   input wire logic               o_tdo_oe_n,
   input wire logic [BSR_LEN-1:0] o_preload,
   input wire logic               o_ring_drive,
   input wire logic               o_qbus_hiz,
   input wire logic               i_wb_cyc,
   input wire logic               i_wb_stb,
   input wire logic               i_wb_we,
   input wire logic [7:0]         i_wb_adr,
   input wire logic               o_wb_ack,
   input wire logic [31:0]        o_wb_dat
);
   logic       tck_q_ff;   // Test clock level one cycle ago
   logic [2:0] hi_cnt_ff;  // Rises seen in a row with mode select high
   // Count consecutive high mode-select rises, saturating at five
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         tck_q_ff  <= 1'h1;
         hi_cnt_ff <= 3'h0;
      end else begin
         tck_q_ff <= i_tck;
         if (i_tck && !tck_q_ff) begin
            hi_cnt_ff <= !i_tms ? 3'h0 : (hi_cnt_ff == 3'h5) ? 3'h5 : hi_cnt_ff + 3'h1;
         end
      end
   end
   default clocking dc @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   tdo_stable_a: assert property (i_tck [*6] |=> $stable(o_tdo) && $stable(o_tdo_oe_n))
      else $error("serial output moved with no test clock fall");
   oe_fall_a: assert property ($fell(o_tdo_oe_n) |-> !$past(i_tck, 2))
      else $error("serial output enabled away from a clock fall");
   reset_pins_a: assert property ($past(i_sys_rst) |->
      o_tdo_oe_n && o_preload[OE_CELL] && !o_ring_drive && !o_wb_ack)
      else $error("pins wrong after power-up reset");
   drive_hiz_a: assert property (o_ring_drive |-> o_qbus_hiz == !o_preload[OE_CELL])
      else $error("enable cell does not control the output bus");
   preload_stable_a: assert property ((i_tck && !i_wb_we) [*8] |=>
      $stable(o_preload) && $stable(o_qbus_hiz))
      else $error("preload or bus float changed with no clock rise");
   tms_reset_a: assert property ($rose(hi_cnt_ff == 3'h5) |->
      ##[0:8] (o_preload[OE_CELL] && !o_ring_drive && o_tdo_oe_n))
      else $error("five high mode-select rises did not reset the port");
   ack_follows_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack && i_clk_en |=> o_wb_ack)
      else $error("bus request not answered next cycle");
   ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("bus acknowledge longer than one cycle");
   idcode_word_a: assert property (o_wb_ack && i_wb_adr == REG_IDCODE && !i_wb_we |->
      o_wb_dat[0] == 1'h1)
      else $error("identification word bit zero not one");
   status_drive_a: assert property (o_wb_ack && i_wb_adr == REG_STATUS && !i_wb_we |->
      o_ring_drive == (o_wb_dat[ST_IR_LSB +: 3] == 3'h0))
      else $error("ring drive disagrees with instruction");
   // Main scenarios reached
   cover property (o_ring_drive && o_qbus_hiz);
   cover property ($fell(o_tdo_oe_n));
   cover property ($rose(hi_cnt_ff == 3'h5));
endmodule : sbt_tap_assertions

bind sbt_tap sbt_tap_assertions sbt_tap_assertions_inst (
   .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_tck(i_tck),
   .i_tms(i_tms), .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n), .o_preload(o_preload),
   .o_ring_drive(o_ring_drive), .o_qbus_hiz(o_qbus_hiz), .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_ack(o_wb_ack),
   .o_wb_dat(o_wb_dat));

// File: tb/sbt_tester.sv
// Test controller model: drives test clock, mode select and serial input.
// Assumes callers enter its tasks just after a system clock rise.
`timescale 1ns/10ps
module sbt_tester (
   input  wire logic i_clock,  // System clock, paces the pins
   input  wire logic i_tdo,    // Resolved serial output wire
   output logic      o_tck,    // Test clock, 64 ns, still high between bits
   output logic      o_tms,    // Mode select
   output logic      o_tdi     // Serial data in, pull-up level when unused
);
   initial begin
      o_tck = 1'h1;
      o_tms = 1'h1;
      o_tdi = 1'h1;
   end
   // One test clock: pins change with the fall, output taken before next fall
   task automatic step(input logic tms, input logic tdi, output logic tdo);
      o_tck <= 1'h0;
      o_tms <= tms;
      o_tdi <= tdi;
      repeat (4) @(posedge i_clock);
      o_tck <= 1'h1;
      repeat (4) @(posedge i_clock);
      tdo = i_tdo;
   endtask : step
   // Five high mode-select rises reach reset from any state
   task automatic tap_reset();
      logic d;
      repeat (5) step(1'h1, 1'h1, d);
   endtask : tap_reset
   // From idle: scan n bits through instruction or data path, update, idle
   task automatic scan(input logic ir, input int n, input logic [127:0] din,
                       output logic [127:0] dout);
      logic d;
      dout = '0;
      step(1'h1, 1'h1, d);
      if (ir) step(1'h1, 1'h1, d);
      step(1'h0, 1'h1, d);
      step(1'h0, 1'h1, d);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], dout[i]);
      end
      step(1'h1, 1'h1, d);
      step(1'h0, 1'h1, d);
      repeat (8) @(posedge i_clock);
   endtask : scan
endmodule : sbt_tester

// File: tb/tb_top.sv
// Self-checking bench for the memory boundary-scan port.
// Assumes the tester model and the bound checker; codes never use reserved values.
`timescale 1ns/10ps
module tb_top
   import sbt_pkg::*;
;
   localparam logic [2:0]   ID_R  = 3'h2;                       // Arbitrary revision
   localparam logic [16:0]  ID_D  = 17'h0ABCD;                  // Arbitrary device field
   localparam logic [10:0]  ID_V  = 11'h155;                    // Arbitrary vendor field
   localparam logic [127:0] ID_X  = {96'h0, ID_R, ID_D, ID_V, 1'h1};
   localparam logic [127:0] PAT_A = {4{32'hC3A5_0F96}};         // Pin ring levels
   localparam logic [127:0] PAT_B = {4{32'h6B2D_6417}};         // Preload, enable cell low
   logic               clock    = 1'h0;                   // System clock
   logic               sys_rst  = 1'h1;                   // Reset, held at start
   logic               clk_en   = 1'h1;                   // Clock enable
   logic [BSR_LEN-1:0] ring     = PAT_A[BSR_LEN-1:0];     // Held stable
   sbt_wb_req_t        wb       = '0;                     // Bus request
   logic               tck, tms, tdi, tdo, tdo_oe_n, ring_drive, qbus_hiz, wb_ack, b;
   logic [BSR_LEN-1:0] preload;                           // Preload latches
   logic [31:0]        wb_dat;                            // Bus read data
   wire logic          tdo_pin = tdo_oe_n ? 1'hZ : tdo;   // Resolved serial wire
   int                 fails = 0, tests_run = 0;
   always #4 clock = ~clock;
   sbt_tap #(.ID_REV(ID_R), .ID_DEVICE(ID_D), .ID_VENDOR(ID_V)) sbt_tap_inst (
      .i_clock(clock), .i_sys_rst(sys_rst), .i_clk_en(clk_en), .i_tck(tck), .i_tms(tms),
      .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n), .i_ring(ring), .o_preload(preload),
      .o_ring_drive(ring_drive), .o_qbus_hiz(qbus_hiz), .i_wb_cyc(wb.cyc), .i_wb_stb(wb.stb),
      .i_wb_we(wb.we), .i_wb_sel(wb.sel), .i_wb_adr(wb.adr), .i_wb_dat(wb.dat),
      .o_wb_ack(wb_ack), .o_wb_dat(wb_dat));
   sbt_tester sbt_tester_inst (.i_clock(clock), .i_tdo(tdo_pin), .o_tck(tck), .o_tms(tms),
      .o_tdi(tdi));
   // Compare and count
   task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Classic single bus cycle, held until acknowledge is sampled
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                          output logic [31:0] rdat);
      wb <= '{cyc: 1'h1, stb: 1'h1, we: we, sel: 4'hF, adr: adr, dat: dat};
      do @(posedge clock); while (wb_ack !== 1'h1);
      rdat = wb_dat;
      wb <= '0;
      @(posedge clock);
   endtask : wb_xfer
   // Verdict and end of run
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   // Watchdog well beyond the expected run
   initial begin
      #400000;
      fails++;
      results();
   end
   // Main sequence
   initial begin
      logic [31:0]  r;
      logic [127:0] d;
      repeat (12) @(posedge clock);
      sys_rst <= 1'h0;
      @(posedge clock);
      chk({tdo_oe_n, preload[OE_CELL], ring_drive, qbus_hiz}, 4'hC);
      wb_xfer(1'h0, REG_STATUS, 32'h0, r);
      chk(r[10:0], 11'h410);
      wb_xfer(1'h0, REG_IDCODE, 32'h0, r);
      chk(r, ID_X[31:0]);
      wb_xfer(1'h0, 8'h0C, 32'h0, r);
      chk(r, 32'h0);
      // Identification word under the power-up instruction
      sbt_tester_inst.step(1'h0, 1'h1, b);
      sbt_tester_inst.scan(1'h0, ID_W, 128'h0, d);
      chk(d, ID_X);
      // Capture pattern, then a one-bit bypass path
      sbt_tester_inst.scan(1'h1, IR_W, 128'h7, d);
      chk(d, 128'h1);
      sbt_tester_inst.scan(1'h0, 4, 128'hB, d);
      chk(d, 128'h6);
      // Snapshot out while preload shifts in
      sbt_tester_inst.scan(1'h1, IR_W, 128'h4, d);
      sbt_tester_inst.scan(1'h0, BSR_LEN, PAT_B, d);
      chk(d, PAT_A[BSR_LEN-1:0]);
      chk({preload, ring_drive, qbus_hiz}, {PAT_B[BSR_LEN-1:0], 2'h0});
      // External test with enable cell low floats the bus
      sbt_tester_inst.scan(1'h1, IR_W, 128'h0, d);
      chk({ring_drive, qbus_hiz}, 2'h3);
      sbt_tester_inst.tap_reset();
      wb_xfer(1'h0, REG_STATUS, 32'h0, r);
      chk(r[10:0], 11'h410);
      sbt_tester_inst.step(1'h0, 1'h1, b);
      sbt_tester_inst.scan(1'h1, IR_W, 128'h0, d);
      chk({ring_drive, qbus_hiz}, 2'h2);
      sbt_tester_inst.scan(1'h1, IR_W, 128'h2, d);
      chk({ring_drive, qbus_hiz}, 2'h1);
      // Clock enable low: a whole test clock goes unseen, controller stays idle
      clk_en <= 1'h0;
      sbt_tester_inst.step(1'h1, 1'h1, b);
      clk_en <= 1'h1;
      wb_xfer(1'h0, REG_STATUS, 32'h0, r);
      chk(r[10:0], 11'h621);
      // Software reset back to identification
      wb_xfer(1'h1, REG_CTRL, 32'h1, r);
      wb_xfer(1'h0, REG_STATUS, 32'h0, r);
      chk(r[10:0], 11'h410);
      results();
   end
endmodule : tb_top
